// [rtl/sdf_consts.svh]
// constants for the decimation filter selector
`ifndef SDF_CONSTS_SVH
`define SDF_CONSTS_SVH

`define SDF_TYPE_W 4
`define SDF_RATE_W 11
`define SDF_SETUPS 8
`define SDF_SEL_W 3
`define SDF_ACC_W 64
`define SDF_CNT_W 17
`define SDF_ORD_W 3

`define SDF_DEF_TYPE 4'h2
`define SDF_DEF_RATE 11'h001
`define SDF_SINC4_MAX 11'h00a
`define SDF_DEC_SHIFT 5
`define SDF_POST1_CYC 17'h00b80
`define SDF_POST2_CYC 17'h00c80
`define SDF_POST3_CYC 17'h00f80
`define SDF_POST4_CYC 17'h01280
`define SDF_REJ_NUM 20'h00005
`define SDF_REJ_DEN 20'h00006
`define SDF_ORDER3 3'h3
`define SDF_ORDER4 3'h4
`define SDF_AVG_LAST 3'h7
`define SDF_AVG_SHIFT 3
`define SDF_FIFO_DEPTH 16

`endif

// [rtl/sdf_pkg.sv]
// types shared by the filter selector and its output buffer
`default_nettype none
`include "sdf_consts.svh"
package sdf_pkg;

  typedef enum logic [`SDF_TYPE_W-1:0] {
    FT_SINC4 = 4'h0,
    FT_SINC4_AVG = 4'h1,
    FT_SINC3 = 4'h2,
    FT_SINC3_REJ = 4'h3,
    FT_SINC3_AVG = 4'h4,
    FT_POST1 = 4'h5,
    FT_POST2 = 4'h6,
    FT_POST3 = 4'h7,
    FT_POST4 = 4'h8
  } sdf_ftype_t;

  typedef struct packed {
    logic [`SDF_TYPE_W-1:0] ftype;
    logic [`SDF_RATE_W-1:0] filterRateWord;
  } sdf_cfg_t;

  typedef struct packed {
    logic [`SDF_SEL_W-1:0] setup;
    logic [`SDF_TYPE_W-1:0] ftype;
    logic [`SDF_ACC_W-1:0] data;
  } sdf_sample_t;

endpackage
`default_nettype wire

// [rtl/sdf_fifo.sv]
// flop-based sample fifo with valid/ready on both sides
`default_nettype none
module sdf_fifo
  import sdf_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] memReg [DEPTH];
  logic [WIDTH-1:0] memNext [DEPTH];
  logic [AW:0] wrReg, wrNext, rdReg, rdNext;
  logic push, pop;

  assign inReady = (wrReg - rdReg) != (AW + 1)'(DEPTH);
  assign outValid = wrReg != rdReg;
  assign outData = memReg[rdReg[AW-1:0]];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    memNext = memReg;
    wrNext = wrReg;
    rdNext = rdReg;
    if (push) begin
      memNext[wrReg[AW-1:0]] = inData;
      wrNext = wrReg + 1'b1;
    end
    if (pop) begin
      rdNext = rdReg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    memReg <= memNext;
    if (rst) begin
      wrReg <= '0;
      rdReg <= '0;
    end else begin
      wrReg <= wrNext;
      rdReg <= rdNext;
    end
  end
endmodule
`default_nettype wire

// [rtl/sdf_filter_select.sv]
// per-setup decimation filter selection and sinc/averaging/post filter chain
// How it works
// - after reset every setup selects filter type 0010, standalone sinc3
// - each setup's filter-type field picks the chain used when converting that setup
// - type 0000 is standalone sinc4; rate word 1 to 10, above 10 treated as 10
// - type 0001 is sinc4 plus average-by-8; rate word clamped to 10
// - type 0010 sinc3 accepts the full rate word range 1 to 2047
// - type 0011 adds a notch at six fifths of the main notch
// - types 0101 to 1000 are post filters; rate word ignored
// - post filters run at 2944, 3200, 3968, 4736 modulator ticks after sinc3
// - all other types take their output rate from the rate word
// - standalone sinc3/sinc4 decimate by 32 times the rate word
// - averaging modes sum eight consecutive sinc outputs
// - averaging modes need no extra settling on the first conversion
// - settled conversion takes 32 times rate word modulator ticks (256 times in averaging modes), post1 2944
`default_nettype none
`include "sdf_consts.svh"
module sdf_filter_select
  import sdf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cfgWrite,
  input wire logic [`SDF_SEL_W-1:0] cfgSetup,
  input wire sdf_cfg_t cfgData,
  input wire logic convRun,
  input wire logic [`SDF_SEL_W-1:0] runSetup,
  input wire logic modBit,
  input wire logic modValid,
  output logic modReady,
  output logic smpValid,
  input wire logic smpReady,
  output sdf_sample_t smpData,
  output logic settled
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b10
  } sdf_state_t;

  function automatic logic isSinc4(input logic [`SDF_TYPE_W-1:0] t);
    return t == FT_SINC4 || t == FT_SINC4_AVG;
  endfunction

  function automatic logic isAvg(input logic [`SDF_TYPE_W-1:0] t);
    return t == FT_SINC4_AVG || t == FT_SINC3_AVG;
  endfunction

  function automatic logic [`SDF_ORD_W-1:0] order(input logic [`SDF_TYPE_W-1:0] t);
    return isSinc4(t) ? `SDF_ORDER4 : `SDF_ORDER3;
  endfunction

  // decimation length in modulator ticks
  function automatic logic [`SDF_CNT_W-1:0] decimLimit(input sdf_cfg_t c);
    logic [`SDF_RATE_W-1:0] r;
    r = (c.filterRateWord == '0) ? `SDF_DEF_RATE : c.filterRateWord;
    if (isSinc4(c.ftype) && r > `SDF_SINC4_MAX) begin
      r = `SDF_SINC4_MAX;
    end
    case (c.ftype)
      FT_POST1: decimLimit = `SDF_POST1_CYC;
      FT_POST2: decimLimit = `SDF_POST2_CYC;
      FT_POST3: decimLimit = `SDF_POST3_CYC;
      FT_POST4: decimLimit = `SDF_POST4_CYC;
      default: decimLimit = `SDF_CNT_W'(r) << `SDF_DEC_SHIFT;
    endcase
  endfunction

  // tick index at which the extra-notch boxcar starts
  function automatic logic [`SDF_CNT_W-1:0] notchStart(input logic [`SDF_CNT_W-1:0] lim);
    logic [19:0] len;
    len = (20'(lim) * `SDF_REJ_NUM) / `SDF_REJ_DEN;
    return lim - `SDF_CNT_W'(len) - 1'b1;
  endfunction

  sdf_cfg_t cfgReg [`SDF_SETUPS];
  sdf_cfg_t cfgNext [`SDF_SETUPS];
  sdf_cfg_t actReg, actNext, cfgSel;
  sdf_state_t stReg, stNext;
  logic runReg;
  logic [`SDF_SEL_W-1:0] setupReg, setupNext;
  logic [`SDF_CNT_W-1:0] limReg, limNext, capReg, capNext, bitCntReg, bitCntNext;
  logic [`SDF_ORD_W-1:0] perReg, perNext;
  logic [2:0] avgCntReg, avgCntNext;
  logic [`SDF_ACC_W+2:0] avgSumReg, avgSumNext;
  logic [`SDF_ACC_W-1:0] integReg [4];
  logic [`SDF_ACC_W-1:0] integNext [4];
  logic [`SDF_ACC_W-1:0] combReg [4];
  logic [`SDF_ACC_W-1:0] combNext [4];
  logic [`SDF_ACC_W-1:0] capValReg, capValNext, tap, diffVal;
  logic [`SDF_ACC_W+2:0] sumNow;
  sdf_sample_t outReg, outNext;
  logic pendReg, pendNext;
  logic restart, accept, dec, emit, fifoInReady;

  assign cfgSel = (cfgWrite && cfgSetup == runSetup) ? cfgData : cfgReg[runSetup];
  // new conversion on start, setup change or rewrite of the active setup
  assign restart = convRun && (!runReg || runSetup != setupReg || (cfgWrite && cfgSetup == runSetup));
  assign accept = stReg != ST_IDLE && !restart && convRun && modValid && !pendReg;
  assign modReady = !pendReg;
  assign settled = stReg == ST_RUN;

  always_comb begin
    cfgNext = cfgReg;
    actNext = actReg;
    stNext = stReg;
    setupNext = setupReg;
    limNext = limReg;
    capNext = capReg;
    bitCntNext = bitCntReg;
    perNext = perReg;
    avgCntNext = avgCntReg;
    avgSumNext = avgSumReg;
    integNext = integReg;
    combNext = combReg;
    capValNext = capValReg;
    outNext = outReg;
    pendNext = pendReg;
    dec = 1'b0;
    emit = 1'b0;
    tap = '0;
    diffVal = '0;
    sumNow = '0;
    if (cfgWrite) begin
      cfgNext[cfgSetup] = cfgData;
    end
    if (pendReg && fifoInReady) begin
      pendNext = 1'b0;
    end
    if (!convRun) begin
      stNext = ST_IDLE;
    end else if (restart) begin
      actNext = cfgSel;
      setupNext = runSetup;
      limNext = decimLimit(cfgSel);
      capNext = notchStart(decimLimit(cfgSel));
      bitCntNext = '0;
      perNext = '0;
      avgCntNext = '0;
      avgSumNext = '0;
      capValNext = '0;
      for (int k = 0; k < 4; k++) begin
        integNext[k] = '0;
        combNext[k] = '0;
      end
      // averaging starts emitting without a settling phase
      stNext = isAvg(cfgSel.ftype) ? ST_RUN : ST_SETTLE;
    end else if (accept) begin
      integNext[0] = integReg[0] + `SDF_ACC_W'(modBit);
      for (int k = 1; k < 4; k++) begin
        integNext[k] = integReg[k] + integNext[k-1];
      end
      if (bitCntReg == capReg) begin
        capValNext = integNext[3];
      end
      if (bitCntReg == limReg - 1'b1) begin
        bitCntNext = '0;
        dec = 1'b1;
        if (isSinc4(actReg.ftype)) begin
          tap = integNext[3];
        end else if (actReg.ftype == FT_SINC3_REJ) begin
          tap = integNext[3] - capValReg;
        end else begin
          tap = integNext[2];
        end
        diffVal = tap;
        for (int k = 0; k < 4; k++) begin
          if (k < int'(order(actReg.ftype))) begin
            combNext[k] = diffVal;
            diffVal = diffVal - combReg[k];
          end
        end
        if (isAvg(actReg.ftype)) begin
          sumNow = avgSumReg + (`SDF_ACC_W + 3)'(diffVal);
          avgCntNext = avgCntReg + 1'b1;
          if (avgCntReg == `SDF_AVG_LAST) begin
            emit = 1'b1;
            avgSumNext = '0;
            diffVal = `SDF_ACC_W'(sumNow >> `SDF_AVG_SHIFT);
          end else begin
            avgSumNext = sumNow;
          end
        end else if (stReg == ST_SETTLE) begin
          if (perReg == order(actReg.ftype) - 1'b1) begin
            emit = 1'b1;
            stNext = ST_RUN;
          end else begin
            perNext = perReg + 1'b1;
          end
        end else begin
          emit = 1'b1;
        end
        if (emit) begin
          outNext.setup = setupReg;
          outNext.ftype = actReg.ftype;
          outNext.data = diffVal;
          pendNext = 1'b1;
        end
      end else begin
        bitCntNext = bitCntReg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int k = 0; k < `SDF_SETUPS; k++) begin
        cfgReg[k] <= '{ftype: `SDF_DEF_TYPE, filterRateWord: `SDF_DEF_RATE};
      end
      actReg <= '{ftype: `SDF_DEF_TYPE, filterRateWord: `SDF_DEF_RATE};
      stReg <= ST_IDLE;
      runReg <= 1'b0;
      setupReg <= '0;
      limReg <= '0;
      capReg <= '0;
      bitCntReg <= '0;
      perReg <= '0;
      avgCntReg <= '0;
      avgSumReg <= '0;
      for (int k = 0; k < 4; k++) begin
        integReg[k] <= '0;
        combReg[k] <= '0;
      end
      capValReg <= '0;
      outReg <= '0;
      pendReg <= 1'b0;
    end else begin
      cfgReg <= cfgNext;
      actReg <= actNext;
      stReg <= stNext;
      runReg <= convRun;
      setupReg <= setupNext;
      limReg <= limNext;
      capReg <= capNext;
      bitCntReg <= bitCntNext;
      perReg <= perNext;
      avgCntReg <= avgCntNext;
      avgSumReg <= avgSumNext;
      integReg <= integNext;
      combReg <= combNext;
      capValReg <= capValNext;
      outReg <= outNext;
      pendReg <= pendNext;
    end
  end

  sdf_fifo #(
    .WIDTH($bits(sdf_sample_t)),
    .DEPTH(`SDF_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .inValid(pendReg),
    .inReady(fifoInReady),
    .inData(outReg),
    .outValid(smpValid),
    .outReady(smpReady),
    .outData(smpData)
  );

  // checking helpers
  logic allDefault;
  logic [3:0] decSinceEmit;
  always_comb begin
    allDefault = 1'b1;
    for (int k = 0; k < `SDF_SETUPS; k++) begin
      if (cfgReg[k].ftype != FT_SINC3 || cfgReg[k].filterRateWord != `SDF_DEF_RATE) begin
        allDefault = 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst || restart || emit) begin
      decSinceEmit <= '0;
    end else if (dec) begin
      decSinceEmit <= decSinceEmit + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_rej48;
    restart && cfgSel.ftype == FT_SINC3_REJ && cfgSel.filterRateWord == 11'h030;
  endsequence
  sequence s_avgDone;
    emit && isAvg(actReg.ftype);
  endsequence

  a_reset_default: assert property ($fell(rst) |-> allDefault)
    else $error("setups not at sinc3 default after reset");
  a_setup_latch: assert property (restart |=> actReg == $past(cfgSel) && stReg != ST_IDLE)
    else $error("active setup not taken on restart");
  a_sinc4_clamp: assert property (stReg != ST_IDLE && isSinc4(actReg.ftype) |-> limReg <= 17'h00140)
    else $error("sinc4 rate word not clamped to 10");
  a_sinc3_range: assert property (restart && cfgSel.ftype == FT_SINC3 && cfgSel.filterRateWord != '0
    |=> limReg == {1'b0, $past(cfgSel.filterRateWord), 5'h00})
    else $error("sinc3 decimation not 32 times rate word");
  a_notch_place: assert property (s_rej48 |=> limReg == 17'h00600 && capReg == 17'h000ff)
    else $error("extra notch not at six fifths of main notch");
  a_post_fixed: assert property (restart && cfgSel.ftype == FT_POST1 |=> limReg == 17'h00b80)
    else $error("post filter 1 period not 2944");
  a_dec_period: assert property (dec |-> bitCntReg == limReg - 17'h00001 ##1 bitCntReg == '0)
    else $error("decimation not at end of period");
  a_avg_eight: assert property (s_avgDone |-> decSinceEmit == 4'h7 ##1 pendReg)
    else $error("average not over eight outputs");
  a_settle_first: assert property (stReg == ST_SETTLE && dec |-> emit == (perReg == order(actReg.ftype) - 3'h1))
    else $error("unsettled standalone output emitted");
  a_out_hold: assert property (pendReg && !fifoInReady |=> pendReg && $stable(outReg))
    else $error("pending sample lost under back-pressure");

endmodule
`default_nettype wire

// [test/sdf_mod_src.sv]
// modulator bitstream source standing in front of the filter selector
`default_nettype none
module sdf_mod_src (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic slow,
  input wire logic modReady,
  output logic modBit,
  output logic modValid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic gap;
  // tick held until taken; idle bit toggles
  always @(posedge core_clk) begin
    if (rst) begin
      modValid <= 1'h0;
      modBit <= 1'h0;
      gap <= 1'h0;
    end else if (!(modValid && !modReady)) begin
      gap <= slow && !gap;
      modValid <= enable && !gap;
      modBit <= (enable && !gap) ? 1'h1 : !modBit;
    end
  end
endmodule
`default_nettype wire

// [test/sdf_filter_select_tb.sv]
// self-checking bench for the decimation filter selector
`default_nettype none
`include "sdf_consts.svh"
module sdf_filter_select_tb
  import sdf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic cfgWrite = 1'h0;
  logic [`SDF_SEL_W-1:0] cfgSetup = '0;
  sdf_cfg_t cfgData = '0;
  logic convRun = 1'h0;
  logic [`SDF_SEL_W-1:0] runSetup = '0;
  logic srcSlow = 1'h0;
  logic smpReady = 1'h1;
  logic clrTicks = 1'h0;
  logic modBit;
  logic modValid;
  logic modReady;
  logic smpValid;
  logic settled;
  sdf_sample_t smpData;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int ticks = 0;
  int stamps[$];
  sdf_sample_t taken[$];
  int postCyc[4] = '{2944, 3200, 3968, 4736};

  always #4 core_clk = ~core_clk;

  sdf_filter_select uut (
    .core_clk(core_clk),
    .rst(rst),
    .cfgWrite(cfgWrite),
    .cfgSetup(cfgSetup),
    .cfgData(cfgData),
    .convRun(convRun),
    .runSetup(runSetup),
    .modBit(modBit),
    .modValid(modValid),
    .modReady(modReady),
    .smpValid(smpValid),
    .smpReady(smpReady),
    .smpData(smpData),
    .settled(settled)
  );

  sdf_mod_src srcModel (
    .core_clk(core_clk),
    .rst(rst),
    .enable(convRun),
    .slow(srcSlow),
    .modReady(modReady),
    .modBit(modBit),
    .modValid(modValid)
  );

  // accepted ticks since restart, stamped on each sample taken
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (clrTicks) begin
      ticks <= 0;
    end else if (modValid && modReady && convRun) begin
      ticks <= ticks + 1;
    end
    if (smpValid && smpReady) begin
      stamps.push_back(ticks);
      taken.push_back(smpData);
    end
  end

  always @(negedge core_clk) begin
    if (cycles == 90000) begin
      mismatches++;
      $display("ERROR run time expected below 90000 cycles seen %0d", cycles);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // program a setup, run it, time the first two samples
  task automatic run_cfg(input logic [2:0] setup, input logic doWrite, input logic [3:0] ftype,
      input logic [10:0] rate, input int first, input int gap, input logic [63:0] expData);
    int n;
    @(negedge core_clk);
    if (doWrite) begin
      cfgWrite = 1'h1;
      cfgSetup = setup;
      cfgData.ftype = ftype;
      cfgData.filterRateWord = rate;
      @(negedge core_clk);
      cfgWrite = 1'h0;
    end
    runSetup = setup;
    convRun = 1'h1;
    clrTicks = 1'h1;
    stamps.delete();
    taken.delete();
    @(negedge core_clk);
    clrTicks = 1'h0;
    n = 0;
    while (stamps.size() < 2 && n < 2 * (first + gap) + 200) begin
      @(negedge core_clk);
      n++;
    end
    check("settled", 64'h1, 64'(settled));
    convRun = 1'h0;
    check("sample count", 64'h2, 64'(stamps.size()));
    if (stamps.size() >= 2) begin
      check("first conversion ticks", 64'(first), 64'(stamps[0]));
      check("settled conversion ticks", 64'(gap), 64'(stamps[1] - stamps[0]));
      check("sample filter type", 64'(ftype), 64'(taken[1].ftype));
      check("sample setup", 64'(setup), 64'(taken[1].setup));
      if (expData != 64'h0) begin
        check("sample data", expData, taken[1].data);
      end
    end
    repeat (12) @(negedge core_clk);
  endtask

  // consumer stalls until the buffer refuses, then drains it empty
  task automatic fill_drain();
    int n;
    @(negedge core_clk);
    smpReady = 1'h0;
    runSetup = 3'h0;
    convRun = 1'h1;
    repeat (800) @(negedge core_clk);
    check("modReady with buffer full", 64'h0, 64'(modReady));
    check("smpValid with buffer full", 64'h1, 64'(smpValid));
    convRun = 1'h0;
    smpReady = 1'h1;
    stamps.delete();
    taken.delete();
    n = 0;
    while (smpValid !== 1'h0 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    checked++;
    if (taken.size() < `SDF_FIFO_DEPTH || taken.size() > `SDF_FIFO_DEPTH + 1) begin
      mismatches++;
      $display("ERROR drained words expected 16 or 17 seen %0d", taken.size());
    end
  endtask

  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'h0;
    run_cfg(3'h0, 1'h0, 4'h2, 11'h001, 96, 32, 64'h8000);
    run_cfg(3'h1, 1'h1, 4'h0, 11'h014, 1280, 320, 64'h271000000);
    run_cfg(3'h2, 1'h1, 4'h1, 11'h00f, 2560, 2560, 64'h271000000);
    run_cfg(3'h3, 1'h1, 4'h3, 11'h030, 4608, 1536, 64'h0);
    srcSlow = 1'h1;
    run_cfg(3'h4, 1'h1, 4'h4, 11'h001, 256, 256, 64'h8000);
    srcSlow = 1'h0;
    run_cfg(3'h6, 1'h1, 4'h2, 11'h005, 480, 160, 64'h3e8000);
    for (int k = 0; k < 4; k++) begin
      run_cfg(3'h7, 1'h1, 4'(5 + k), 11'h7ff, 3 * postCyc[k], postCyc[k], 64'h0);
    end
    run_cfg(3'h0, 1'h0, 4'h2, 11'h001, 96, 32, 64'h8000);
    fill_drain();
    give_verdict();
  end
endmodule
`default_nettype wire
